// [hdl/jsp_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module jsp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic push, pop;

  assign in_ready = (wr_ff - rd_ff) != (AW + 1)'(DEPTH);
  assign out_valid = wr_ff != rd_ff;
  assign out_data = mem_ff[rd_ff[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
    end
    else
    begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
    if (push)
    begin
      mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
  end

  no_overfill_a: assert property (@(posedge mclk) disable iff (srst)
    !in_ready && !pop |=> (wr_ff - rd_ff) == (AW + 1)'(DEPTH))
    else $error("fifo count wrong while full");

endmodule
`default_nettype wire

// [hdl/jsp_pkg.sv]
`default_nettype none
package jsp_pkg;

  // ----------------------------------------
  // widths and codes
  // ----------------------------------------
  localparam int unsigned IR_W = 4;
  localparam int unsigned DR_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET_VAL = 4'hf;
  localparam logic [3:0] INSTR_DATA = 4'h2;
  localparam logic [3:0] INSTR_BYPASS = 4'hf;
  localparam logic [7:0] DR_RESET_VAL = 8'h00;
  localparam int unsigned SYNC_STAGES = 2;
  // test clock period in the bench, ns; tck is sampled, not a clock domain
  localparam int unsigned TCK_PERIOD_NS = 64;
  localparam int unsigned MCLK_PERIOD_NS = 8;
  localparam int unsigned TCK_HALF_CYCLES = (TCK_PERIOD_NS / 2) / MCLK_PERIOD_NS;

  // ----------------------------------------
  // tap states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
    ST_UP_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UP_IR = 4'hf
  } jsp_state_type;

  // ----------------------------------------
  // pin bundle from the test controller
  // ----------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst;
    logic emulator_pin_zero;
    logic emulator_pin_one_or_disable;
  } jsp_pins_type;

endpackage
`default_nettype wire

// [hdl/jsp_tap.sv]
// Operation
// - sample mode and data on test clock rise
// - data out changes only on falling edge
// - data out floats unless scanning out
// - disable condition low floats data out only with pin zero high and reset pin low
// - reset pin low: port ignored, functional
`timescale 1ns/1ps
`default_nettype none
module jsp_tap #(
  parameter int unsigned WIDTH = jsp_pkg::DR_W,
  parameter int unsigned DEPTH = jsp_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic srst,
  input wire jsp_pkg::jsp_pins_type pins,
  output logic tdo_out,
  output logic tdo_oe,
  input wire logic [WIDTH-1:0] tx_word,
  output logic [WIDTH-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic overflow
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int unsigned PW = $bits(jsp_pkg::jsp_pins_type);
  jsp_pkg::jsp_pins_type meta_ff, pin_ff;
  logic tck_old_ff;
  logic tck_rise, tck_fall, off_now, trst_on;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      meta_ff <= PW'(0);
      pin_ff <= PW'(0);
      tck_old_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pins;
      pin_ff <= meta_ff;
      tck_old_ff <= pin_ff.tck;
    end
  end

  assign tck_rise = pin_ff.tck && !tck_old_ff;
  assign tck_fall = !pin_ff.tck && tck_old_ff;
  assign trst_on = pin_ff.trst;
  // off only counts when the controller also forces the reset pin low
  assign off_now = !pin_ff.trst && pin_ff.emulator_pin_zero
    && !pin_ff.emulator_pin_one_or_disable;

  // ----------------------------------------
  // tap state machine
  // ----------------------------------------
  function automatic jsp_pkg::jsp_state_type tap_next(
    input jsp_pkg::jsp_state_type s, input logic m);
    case (s)
      jsp_pkg::ST_RESET: tap_next = m ? jsp_pkg::ST_RESET : jsp_pkg::ST_IDLE;
      jsp_pkg::ST_IDLE: tap_next = m ? jsp_pkg::ST_SEL_DR : jsp_pkg::ST_IDLE;
      jsp_pkg::ST_SEL_DR: tap_next = m ? jsp_pkg::ST_SEL_IR : jsp_pkg::ST_CAP_DR;
      jsp_pkg::ST_CAP_DR: tap_next = m ? jsp_pkg::ST_EX1_DR : jsp_pkg::ST_SH_DR;
      jsp_pkg::ST_SH_DR: tap_next = m ? jsp_pkg::ST_EX1_DR : jsp_pkg::ST_SH_DR;
      jsp_pkg::ST_EX1_DR: tap_next = m ? jsp_pkg::ST_UP_DR : jsp_pkg::ST_PA_DR;
      jsp_pkg::ST_PA_DR: tap_next = m ? jsp_pkg::ST_EX2_DR : jsp_pkg::ST_PA_DR;
      jsp_pkg::ST_EX2_DR: tap_next = m ? jsp_pkg::ST_UP_DR : jsp_pkg::ST_SH_DR;
      jsp_pkg::ST_UP_DR: tap_next = m ? jsp_pkg::ST_SEL_DR : jsp_pkg::ST_IDLE;
      jsp_pkg::ST_SEL_IR: tap_next = m ? jsp_pkg::ST_RESET : jsp_pkg::ST_CAP_IR;
      jsp_pkg::ST_CAP_IR: tap_next = m ? jsp_pkg::ST_EX1_IR : jsp_pkg::ST_SH_IR;
      jsp_pkg::ST_SH_IR: tap_next = m ? jsp_pkg::ST_EX1_IR : jsp_pkg::ST_SH_IR;
      jsp_pkg::ST_EX1_IR: tap_next = m ? jsp_pkg::ST_UP_IR : jsp_pkg::ST_PA_IR;
      jsp_pkg::ST_PA_IR: tap_next = m ? jsp_pkg::ST_EX2_IR : jsp_pkg::ST_PA_IR;
      jsp_pkg::ST_EX2_IR: tap_next = m ? jsp_pkg::ST_UP_IR : jsp_pkg::ST_SH_IR;
      jsp_pkg::ST_UP_IR: tap_next = m ? jsp_pkg::ST_SEL_DR : jsp_pkg::ST_IDLE;
      default: tap_next = jsp_pkg::ST_RESET;
    endcase
  endfunction

  jsp_pkg::jsp_state_type st_ff, nxt_st;
  logic [jsp_pkg::IR_W-1:0] ir_sh_ff, ir_ff, nxt_ir_sh, nxt_ir;
  logic [WIDTH-1:0] dr_ff, nxt_dr;
  logic byp_ff, nxt_byp;
  logic sel_data, push_valid, push_ready, ovf_ff, nxt_ovf;

  assign sel_data = ir_ff == jsp_pkg::INSTR_DATA;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_ir_sh = ir_sh_ff;
    nxt_ir = ir_ff;
    nxt_dr = dr_ff;
    nxt_byp = byp_ff;
    nxt_ovf = ovf_ff;
    push_valid = 1'b0;
    if (!trst_on)
    begin
      // port pins are ignored entirely while the reset pin is low
      nxt_st = jsp_pkg::ST_RESET;
      nxt_ir = jsp_pkg::IR_RESET_VAL;
    end
    else if (tck_rise)
    begin
      nxt_st = tap_next(st_ff, pin_ff.tms);
      case (st_ff)
        jsp_pkg::ST_RESET: nxt_ir = jsp_pkg::IR_RESET_VAL;
        jsp_pkg::ST_CAP_IR: nxt_ir_sh = jsp_pkg::IR_CAPTURE;
        jsp_pkg::ST_SH_IR: nxt_ir_sh = {pin_ff.tdi, ir_sh_ff[jsp_pkg::IR_W-1:1]};
        jsp_pkg::ST_UP_IR: nxt_ir = ir_sh_ff;
        jsp_pkg::ST_CAP_DR:
        begin
          nxt_dr = tx_word;
          nxt_byp = 1'b0;
        end
        jsp_pkg::ST_SH_DR:
        begin
          if (sel_data)
          begin
            nxt_dr = {pin_ff.tdi, dr_ff[WIDTH-1:1]};
          end
          else
          begin
            nxt_byp = pin_ff.tdi;
          end
        end
        jsp_pkg::ST_UP_DR:
        begin
          // tck cannot be stalled, so a word meeting a full fifo is lost and flagged
          push_valid = sel_data;
          nxt_ovf = ovf_ff || (sel_data && !push_ready);
        end
        default: nxt_st = nxt_st;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_ff <= jsp_pkg::ST_RESET;
      ir_sh_ff <= jsp_pkg::IR_RESET_VAL;
      ir_ff <= jsp_pkg::IR_RESET_VAL;
      dr_ff <= jsp_pkg::DR_RESET_VAL;
      byp_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      ir_sh_ff <= nxt_ir_sh;
      ir_ff <= nxt_ir;
      dr_ff <= nxt_dr;
      byp_ff <= nxt_byp;
      ovf_ff <= nxt_ovf;
    end
  end

  // ----------------------------------------
  // data out driver
  // ----------------------------------------
  logic tdo_ff, oe_ff, nxt_tdo, nxt_oe, in_shift;

  assign in_shift = st_ff == jsp_pkg::ST_SH_IR || st_ff == jsp_pkg::ST_SH_DR;

  always_comb
  begin
    nxt_tdo = tdo_ff;
    nxt_oe = oe_ff;
    if (tck_fall)
    begin
      nxt_oe = in_shift;
      nxt_tdo = st_ff == jsp_pkg::ST_SH_IR ? ir_sh_ff[0] :
        (sel_data ? dr_ff[0] : byp_ff);
    end
    if (off_now || !trst_on)
    begin
      nxt_oe = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      tdo_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else
    begin
      tdo_ff <= nxt_tdo;
      oe_ff <= nxt_oe;
    end
  end

  assign tdo_out = tdo_ff;
  assign tdo_oe = oe_ff;
  assign overflow = ovf_ff;

  // ----------------------------------------
  // received words toward the user side
  // ----------------------------------------
  jsp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(dr_ff),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence shift_fall_s;
    tck_fall && in_shift && trst_on;
  endsequence

  property oe_on_p;
    @(posedge mclk) disable iff (srst) shift_fall_s |=> oe_ff;
  endproperty

  tdo_fall_only_a: assert property (@(posedge mclk) disable iff (srst)
    $changed(tdo_ff) |-> $past(tck_fall))
    else $error("data out changed off a falling edge");

  oe_rise_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(oe_ff) |-> $past(tck_fall && in_shift))
    else $error("data out enabled outside a shift");

  oe_shift_a: assert property (oe_on_p)
    else $error("data out not enabled in a shift");

  off_float_a: assert property (@(posedge mclk) disable iff (srst)
    off_now |=> !oe_ff)
    else $error("data out driven while disabled");

  trst_reset_a: assert property (@(posedge mclk) disable iff (srst)
    !trst_on |=> st_ff == jsp_pkg::ST_RESET)
    else $error("state not reset by reset pin");

  tap_hold_a: assert property (@(posedge mclk) disable iff (srst)
    trst_on && !tck_rise |=> $stable(st_ff))
    else $error("state moved without a rising edge");

  dr_sample_a: assert property (@(posedge mclk) disable iff (srst)
    tck_rise && trst_on && st_ff == jsp_pkg::ST_SH_DR && sel_data
    |=> dr_ff[WIDTH-1] == $past(pin_ff.tdi))
    else $error("data bit not sampled on rise");

  ir_update_a: assert property (@(posedge mclk) disable iff (srst)
    tck_rise && trst_on && st_ff == jsp_pkg::ST_UP_IR |=> ir_ff == $past(ir_sh_ff))
    else $error("instruction not updated");

  ignore_pins_a: assert property (@(posedge mclk) disable iff (srst)
    !trst_on |-> !push_valid ##1 st_ff == jsp_pkg::ST_RESET)
    else $error("port acted while reset pin low");

endmodule
`default_nettype wire

// [verif/jsp_ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module jsp_ctl_model (
  input wire logic mclk,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  output var jsp_pkg::jsp_pins_type pins
);
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // tck stands low between frames
  initial
  begin
    pins = '0;
    pins.trst = 1'b1;
    pins.emulator_pin_one_or_disable = 1'b1;
  end

  task automatic lines(input logic t, input logic e0, input logic e1);
    begin
      @(negedge mclk);
      pins.trst = t;
      pins.emulator_pin_zero = e0;
      pins.emulator_pin_one_or_disable = e1;
    end
  endtask

  // one test clock: 4 mclk low, 4 high; tdo read just before the fall
  task automatic tick(input logic ms, input logic di, output logic dq, output logic oe,
    output logic st);
    logic early;
    begin
      pins.tms = ms;
      pins.tdi = di;
      repeat (4) @(negedge mclk);
      pins.tck = 1'b1;
      @(negedge mclk);
      early = tdo_out;
      repeat (3) @(negedge mclk);
      dq = tdo_out;
      oe = tdo_oe;
      st = (early === dq);
      pins.tck = 1'b0;
    end
  endtask

  task automatic to_idle();
    logic dq, oe, st;
    begin
      repeat (5) tick(1'b1, 1'b1, dq, oe, st);
      tick(1'b0, 1'b1, dq, oe, st);
    end
  endtask

  // from idle through a shift of n bits back to idle
  task automatic scan(input logic ir, input logic [7:0] din, input int n,
    output logic [7:0] dout, output logic ok);
    logic dq, oe, st;
    begin
      dout = 8'h00;
      ok = 1'b1;
      tick(1'b1, 1'b1, dq, oe, st);
      if (ir)
        tick(1'b1, 1'b1, dq, oe, st);
      tick(1'b0, 1'b1, dq, oe, st);
      tick(1'b0, 1'b1, dq, oe, st);
      for (int i = 0; i < n; i++)
      begin
        tick(i == n - 1, din[i], dq, oe, st);
        dout[i] = dq;
        ok = ok & oe & st;
      end
      tick(1'b1, 1'b1, dq, oe, st);
      ok = ok & ~oe;
      tick(1'b0, 1'b1, dq, oe, st);
    end
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk;
  logic srst;
  logic rx_ready;
  logic [7:0] tx_word;
  logic [7:0] rx_data;
  logic tdo_out;
  logic tdo_oe;
  logic rx_valid;
  logic overflow;
  jsp_pkg::jsp_pins_type pins;
  int err_total;
  int checks_done;
  logic [7:0] d;
  logic ok;

  jsp_tap #(.WIDTH(8), .DEPTH(16)) uut (.mclk(mclk), .srst(srst), .pins(pins),
    .tdo_out(tdo_out), .tdo_oe(tdo_oe), .tx_word(tx_word), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .overflow(overflow));
  jsp_ctl_model ctl (.mclk(mclk), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .pins(pins));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic cmp1(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  task automatic pop(input logic [7:0] e);
    @(negedge mclk);
    cmp1("rx_valid", 1'b1, rx_valid);
    cmp8("rx_data", e, rx_data);
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
  endtask

  task automatic wrap_up();
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    cmp1("idle_oe", 1'b0, tdo_oe);
    cmp1("reset_valid", 1'b0, rx_valid);
    cmp1("reset_overflow", 1'b0, overflow);
  endtask

  // mid-run reset must clear the sticky flag and park the port
  task automatic t_rerun();
    srst = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    ctl.to_idle();
  endtask

  task automatic t_data();
    ctl.scan(1'b1, {4'h0, jsp_pkg::INSTR_DATA}, 4, d, ok);
    cmp8("ir_capture", {4'h0, jsp_pkg::IR_CAPTURE}, d);
    cmp1("ir_oe", 1'b1, ok);
    tx_word = 8'h5a;
    ctl.scan(1'b0, 8'ha3, 8, d, ok);
    cmp8("dr_out", 8'h5a, d);
    cmp1("dr_oe", 1'b1, ok);
    pop(8'ha3);
  endtask

  // bypass: one captured zero, then tdi delayed by one bit
  task automatic t_bypass(input logic ir, input logic [7:0] din);
    ctl.scan(ir, 8'h05, 4, d, ok);
    ctl.scan(1'b0, din, 8, d, ok);
    cmp8("bypass_out", {din[6:0], 1'b0}, d);
    cmp1("bypass_push", 1'b0, rx_valid);
  endtask

  task automatic t_fill();
    ctl.scan(1'b1, {4'h0, jsp_pkg::INSTR_DATA}, 4, d, ok);
    for (int i = 0; i < 17; i++)
      ctl.scan(1'b0, 8'h30 + i[7:0], 8, d, ok);
    cmp1("overflow", 1'b1, overflow);
    for (int i = 0; i < 16; i++)
      pop(8'h30 + i[7:0]);
    cmp1("drained", 1'b0, rx_valid);
  endtask

  // port off in mid-shift, then traffic ignored, then reset state seen
  task automatic t_off();
    logic dq;
    logic oe;
    logic st;
    ctl.tick(1'b1, 1'b1, dq, oe, st);
    ctl.tick(1'b0, 1'b1, dq, oe, st);
    ctl.tick(1'b0, 1'b1, dq, oe, st);
    ctl.tick(1'b0, 1'b1, dq, oe, st);
    cmp1("shift_oe", 1'b1, oe);
    ctl.lines(1'b0, 1'b1, 1'b0);
    repeat (4) @(negedge mclk);
    cmp1("off_oe", 1'b0, tdo_oe);
    ctl.scan(1'b0, 8'h77, 8, d, ok);
    cmp1("ignored_oe", 1'b0, ok);
    cmp1("ignored_push", 1'b0, rx_valid);
    ctl.lines(1'b1, 1'b0, 1'b1);
    ctl.tick(1'b0, 1'b1, dq, oe, st);
    t_bypass(1'b0, 8'h81);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    err_total = 0;
    checks_done = 0;
    srst = 1'b1;
    rx_ready = 1'b0;
    tx_word = 8'h00;
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    ctl.to_idle();
    t_data();
    t_bypass(1'b1, 8'hc5);
    t_fill();
    t_rerun();
    t_off();
    wrap_up();
  end

  // scans total about 2700 mclk; leave wide margin
  initial
  begin
    repeat (30000) @(posedge mclk);
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
